// File: hw/pcs_pkg.sv
package pcs_pkg;
   // ------------------------------------------------------------
   // Register selects (word index on the host register port)
   // ------------------------------------------------------------
   localparam logic [1:0] PCS_REG_CTRL = 2'h0;
   localparam logic [1:0] PCS_REG_STAT = 2'h1;
   localparam int PCS_DW = 16;

   // ------------------------------------------------------------
   // Control/status register bit positions
   // ------------------------------------------------------------
   localparam int B_STATUS_ERR = 15;
   localparam int B_CMD_ERR = 14;
   localparam int B_RX_DONE = 13;
   localparam int B_TX_DONE = 12;
   localparam int B_CMD_DONE = 11;
   localparam int B_RX_LACK = 10;
   localparam int B_UNSOL = 8;
   localparam int B_SUMMARY = 7;
   localparam int B_INT_EN = 6;
   localparam int B_RESET = 5;
   localparam int B_FLAG_HI = 15;
   localparam int B_FLAG_LO = 8;
   localparam int NUM_FLAGS = 8;
   localparam logic [7:0] FLAG_MASK = 8'hfd;

   // ------------------------------------------------------------
   // State register bit positions
   // ------------------------------------------------------------
   localparam int B_XCVR_FAULT = 15;
   localparam int B_CABLE_FAULT = 14;
   localparam int B_TEST_HI = 13;
   localparam int B_TEST_LO = 8;
   localparam int B_TIMEOUT = 7;
   localparam int TEST_W = 6;

   // ------------------------------------------------------------
   // Port commands
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0, CMD_GET_BLOCK = 4'h1, CMD_GET_CMD = 4'h2, CMD_SELFTEST = 4'h3,
      CMD_START = 4'h4, CMD_BOOT = 4'h5, CMD_RSV6 = 4'h6, CMD_RSV7 = 4'h7,
      CMD_POLL = 4'h8, CMD_RSV_LO = 4'h9, CMD_RSV_HI = 4'he, CMD_STOP = 4'hf
   } pcs_cmd_type;

   // ------------------------------------------------------------
   // Adapter state codes
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET = 4'h0, ST_LOAD = 4'h1, ST_READY = 4'h2, ST_RUNNING = 4'h3,
      ST_UNUSED = 4'h4, ST_BUS_HALT = 4'h5, ST_NET_HALT = 4'h6, ST_BOTH_HALT = 4'h7
   } pcs_state_code_type;
endpackage

// File: hw/pcs_if.sv
`timescale 1ns/100ps
// Command decode handshake between register bank and decoder
interface pcs_cmd_if;
   logic valid;
   logic [3:0] code;
   logic [3:0] state;
   logic done_set;
   logic stop;
   logic pass;
   modport bank (output valid, output code, output state,
                 input done_set, input stop, input pass);
   modport dec (input valid, input code, input state,
                output done_set, output stop, output pass);
endinterface

// File: hw/pcs_cmd_decode.sv
`timescale 1ns/100ps
module pcs_cmd_decode
   import pcs_pkg::*;
(
   pcs_cmd_if.dec cmd
);
   // ------------------------------------------------------------
   // Local command decode
   // ------------------------------------------------------------
   // Reserved codes 9 to 14 only set done; stop only from running
   always_comb begin
      cmd.done_set = 1'b0;
      cmd.stop = 1'b0;
      cmd.pass = 1'b0;
      if (cmd.valid) begin
         if (cmd.code >= CMD_RSV_LO && cmd.code <= CMD_RSV_HI) begin
            cmd.done_set = 1'b1;
         end else if (cmd.code == CMD_STOP) begin
            cmd.stop = (cmd.state == ST_RUNNING);
         end else begin
            cmd.pass = 1'b1;
         end
      end
   end
endmodule

// File: hw/pcs_regs.sv
`timescale 1ns/100ps
//----------------------------------------------------------------
// Summary of operation
// - Reserved command codes 9 to 14 do nothing but set the command-done flag.
// - Stop command returns a running adapter to ready; otherwise ignored.
// - Only the adapter sets flags 15 to 10 and 8; host clears by writing one.
// - Interrupt summary bit is read-only; host writes to it are ignored.
// - Reset bit is write-only and always reads as zero.
// - Status bit 15 reads one on transceiver supply or breaker failure.
// - Status bit 14 reads one when the module cable is badly seated.
// - Bits 13:8 hold the failed self-test code; zero means no failure.
// - Bit 7 marks a bus timeout during a command, valid after command error.
// - Four-bit state field uses codes 0 to 7; 8 and above unassigned.
// - Fatal error enters both-halted and sets unsolicited flag; only reset leaves.
// - Reset state is transitory; after a good reset state reads ready.
// - Summary bit always equals OR of control bits 15 to 8.
// - Writing reset returns to power-up; afterwards command-done and summary set.
//----------------------------------------------------------------
module pcs_regs
   import pcs_pkg::*;
#(
   parameter int RESET_CYCLES = 4
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   // Host register port
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic [1:0] host_sel_in,
   input wire logic [PCS_DW-1:0] host_wdata_in,
   output logic [PCS_DW-1:0] host_rdata_out,
   output logic host_irq_out,
   // Firmware side
   input wire logic [NUM_FLAGS-1:0] fw_flag_set_in,
   input wire logic fw_state_wr_in,
   input wire logic [3:0] fw_state_in,
   input wire logic fw_fatal_in,
   input wire logic fw_timeout_in,
   input wire logic fw_test_wr_in,
   input wire logic [TEST_W-1:0] fw_test_code_in,
   input wire logic xcvr_fault_pin_in,
   input wire logic cable_fault_pin_in,
   output logic cmd_valid_out,
   output logic [3:0] cmd_code_out,
   output logic adapter_reset_out
);
   import pcs_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_chk
      $error("RESET_CYCLES out of range");
   end

   // ------------------------------------------------------------
   // State, declarations
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001, SEQ_RESET = 3'b010, SEQ_DONE = 3'b100
   } pcs_seq_type;

   pcs_cmd_if cmd();

   logic [NUM_FLAGS-1:0] flags, next_flags;
   logic int_en, next_int_en;
   logic [3:0] cmd_code, next_cmd_code;
   logic cmd_valid, next_cmd_valid;
   logic [3:0] state, next_state;
   logic [TEST_W-1:0] test_code, next_test_code;
   logic timeout, next_timeout;
   logic [1:0] xcvr_sync, cable_sync;
   logic [PCS_DW-1:0] rdata, next_rdata;
   logic irq, next_irq;
   logic adp_reset, next_adp_reset;
   pcs_seq_type seq, next_seq;
   logic [7:0] rst_cnt, next_rst_cnt;
   logic ctrl_wr;
   logic summary;
   logic [PCS_DW-1:0] ctrl_view, stat_view;

   assign cmd.valid = cmd_valid;
   assign cmd.code = cmd_code;
   assign cmd.state = state;

   // Command decoder
   pcs_cmd_decode u_dec (
      .cmd(cmd)
   );

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         xcvr_sync <= 2'h0;
         cable_sync <= 2'h0;
      end else if (clk_en_in) begin
         xcvr_sync <= {xcvr_sync[0], xcvr_fault_pin_in};
         cable_sync <= {cable_sync[0], cable_fault_pin_in};
      end
   end

   // ------------------------------------------------------------
   // Read views
   // ------------------------------------------------------------
   assign ctrl_wr = host_wr_in && (host_sel_in == PCS_REG_CTRL);
   assign summary = |flags;

   // Control register view; reset bit reads zero
   always_comb begin
      ctrl_view = '0;
      ctrl_view[B_FLAG_HI:B_FLAG_LO] = flags;
      ctrl_view[B_SUMMARY] = summary;
      ctrl_view[B_INT_EN] = int_en;
      ctrl_view[B_RESET] = 1'b0;
      ctrl_view[3:0] = cmd_code;
   end

   // State register view
   always_comb begin
      stat_view = '0;
      stat_view[B_XCVR_FAULT] = xcvr_sync[1];
      stat_view[B_CABLE_FAULT] = cable_sync[1];
      stat_view[B_TEST_HI:B_TEST_LO] = test_code;
      stat_view[B_TIMEOUT] = timeout;
      stat_view[3:0] = state;
   end

   // ------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------
   // Host reset write holds the adapter in reset for a while
   always_comb begin
      next_seq = seq;
      next_rst_cnt = rst_cnt;
      next_adp_reset = 1'b0;
      unique case (seq)
         SEQ_IDLE: begin
            if (ctrl_wr && host_wdata_in[B_RESET]) begin
               next_seq = SEQ_RESET;
               next_rst_cnt = 8'(RESET_CYCLES - 1);
               next_adp_reset = 1'b1;
            end
         end
         SEQ_RESET: begin
            next_adp_reset = 1'b1;
            if (rst_cnt == 8'h00) begin
               next_seq = SEQ_DONE;
               next_adp_reset = 1'b0;
            end else begin
               next_rst_cnt = rst_cnt - 8'h01;
            end
         end
         SEQ_DONE: begin
            next_seq = SEQ_IDLE;
         end
         default: begin
            next_seq = SEQ_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Register bank next values
   // ------------------------------------------------------------
   always_comb begin
      next_flags = flags;
      next_int_en = int_en;
      next_cmd_code = cmd_code;
      next_cmd_valid = 1'b0;
      next_state = state;
      next_test_code = test_code;
      next_timeout = timeout;
      if (seq == SEQ_RESET) begin
         // Power-up values while reset is in progress
         next_flags = '0;
         next_int_en = 1'b0;
         next_cmd_code = 4'h0;
         next_state = ST_RESET;
         next_test_code = '0;
         next_timeout = 1'b0;
      end else if (seq == SEQ_DONE) begin
         next_state = ST_READY;
         next_flags[B_CMD_DONE - B_FLAG_LO] = 1'b1;
      end else begin
         // Host clears by writing one
         if (ctrl_wr) begin
            next_flags = flags & ~(host_wdata_in[B_FLAG_HI:B_FLAG_LO] & FLAG_MASK);
            next_int_en = host_wdata_in[B_INT_EN]; // summary write ignored
            next_cmd_code = host_wdata_in[3:0];
            next_cmd_valid = !host_wdata_in[B_RESET];
         end
         // Firmware sets win over host clears
         next_flags = next_flags | (fw_flag_set_in & FLAG_MASK);
         if (cmd.done_set) begin
            next_flags[B_CMD_DONE - B_FLAG_LO] = 1'b1;
         end
         if (fw_state_wr_in && state != ST_BOTH_HALT) begin
            next_state = fw_state_in;
         end
         if (cmd.stop) begin
            next_state = ST_READY;
         end
         if (fw_test_wr_in) begin
            next_test_code = fw_test_code_in;
         end
         if (fw_timeout_in) begin
            next_timeout = 1'b1;
         end
         if (fw_fatal_in) begin
            next_state = ST_BOTH_HALT;
            next_flags[B_UNSOL - B_FLAG_LO] = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Output next values
   // ------------------------------------------------------------
   always_comb begin
      next_rdata = rdata;
      if (host_rd_in) begin
         unique case (host_sel_in)
            PCS_REG_CTRL: next_rdata = ctrl_view;
            PCS_REG_STAT: next_rdata = stat_view;
            default: next_rdata = '0;
         endcase
      end
      next_irq = (|next_flags) && next_int_en;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         seq <= SEQ_RESET;
         rst_cnt <= 8'(RESET_CYCLES - 1);
         adp_reset <= 1'b1;
         flags <= '0;
         int_en <= 1'b0;
         cmd_code <= 4'h0;
         cmd_valid <= 1'b0;
         state <= ST_RESET;
         test_code <= '0;
         timeout <= 1'b0;
         rdata <= '0;
         irq <= 1'b0;
      end else if (clk_en_in) begin
         seq <= next_seq;
         rst_cnt <= next_rst_cnt;
         adp_reset <= next_adp_reset;
         flags <= next_flags;
         int_en <= next_int_en;
         cmd_code <= next_cmd_code;
         cmd_valid <= next_cmd_valid;
         state <= next_state;
         test_code <= next_test_code;
         timeout <= next_timeout;
         rdata <= next_rdata;
         irq <= next_irq;
      end
   end

   assign host_rdata_out = rdata;
   assign host_irq_out = irq;
   assign cmd_valid_out = cmd_valid && cmd.pass;
   assign cmd_code_out = cmd_code;
   assign adapter_reset_out = adp_reset;
endmodule

// File: test/pcs_regs_asserts.sv
`timescale 1ns/100ps
module pcs_regs_asserts
   import pcs_pkg::*;
#(
   parameter int RESET_CYCLES = 4
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic host_wr_in,
   input wire logic host_rd_in,
   input wire logic [1:0] host_sel_in,
   input wire logic [PCS_DW-1:0] host_wdata_in,
   input wire logic [PCS_DW-1:0] host_rdata_out,
   input wire logic host_irq_out,
   input wire logic xcvr_fault_pin_in,
   input wire logic cable_fault_pin_in,
   input wire logic cmd_valid_out,
   input wire logic adapter_reset_out
);
   localparam int RST_MAX = RESET_CYCLES + 4;
   logic rd_c;
   logic rd_s;
   // Taken reads of each register
   assign rd_c = host_rd_in && clk_en_in && host_sel_in == PCS_REG_CTRL;
   assign rd_s = host_rd_in && clk_en_in && host_sel_in == PCS_REG_STAT;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   AST_RESET_OUT: assert property (disable iff (1'b0) !resetn_in && clk_en_in |=> adapter_reset_out)
      else $error("reset not entered");
   AST_WR_RESET: assert property (host_wr_in && clk_en_in && host_sel_in == PCS_REG_CTRL
      && host_wdata_in[B_RESET] && !adapter_reset_out && !$past(adapter_reset_out)
      |=> adapter_reset_out)
      else $error("reset write ignored");
   AST_RST_LEN: assert property (($rose(resetn_in) || $rose(adapter_reset_out)) |-> ##[1:RST_MAX] !adapter_reset_out)
      else $error("reset sequence too long");
   AST_RD_ZERO: assert property (rd_c |=> !host_rdata_out[B_RESET] && !host_rdata_out[4] && !host_rdata_out[9])
      else $error("zero bits read nonzero");
   AST_SUMMARY: assert property (rd_c |=> host_rdata_out[B_SUMMARY] == |host_rdata_out[B_FLAG_HI:B_FLAG_LO])
      else $error("summary mismatch");
   AST_STAT_ZERO: assert property (rd_s |=> host_rdata_out[6:4] == 3'h0)
      else $error("state view bad zeros");
   AST_IRQ: assert property (rd_c |=> host_irq_out == (host_rdata_out[B_SUMMARY] && host_rdata_out[B_INT_EN]))
      else $error("irq mismatch");
   AST_RSV_CMD: assert property (host_wr_in && clk_en_in && !adapter_reset_out && !host_wdata_in[B_RESET]
      && host_wdata_in[3:0] inside {[4'h9:4'he]} |=> !cmd_valid_out)
      else $error("reserved code issued");
   AST_TRANSCEIVER_POWER_FAULT: assert property ((xcvr_fault_pin_in && clk_en_in)[*4] ##0 rd_s |=> host_rdata_out[B_XCVR_FAULT])
      else $error("power fault not shown");
   AST_CABLE: assert property ((cable_fault_pin_in && clk_en_in)[*4] ##0 rd_s |=> host_rdata_out[B_CABLE_FAULT])
      else $error("cable fault not shown");
   COV_IRQ: cover property (rd_c ##1 host_irq_out);
   COV_RESET: cover property ($rose(adapter_reset_out));
   COV_TIMEOUT: cover property (rd_s ##1 host_rdata_out[B_TIMEOUT]);
endmodule

bind pcs_regs pcs_regs_asserts #(.RESET_CYCLES(RESET_CYCLES)) i_pcs_regs_asserts (
   .core_clk_in(core_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
   .host_wr_in(host_wr_in), .host_rd_in(host_rd_in), .host_sel_in(host_sel_in),
   .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out), .host_irq_out(host_irq_out),
   .xcvr_fault_pin_in(xcvr_fault_pin_in), .cable_fault_pin_in(cable_fault_pin_in),
   .cmd_valid_out(cmd_valid_out), .adapter_reset_out(adapter_reset_out));

// File: test/pcs_host_model.sv
`timescale 1ns/100ps
module pcs_host_model
   import pcs_pkg::*;
(
   input wire logic core_clk_in,
   output logic host_wr_out,
   output logic host_rd_out,
   output logic [1:0] host_sel_out,
   output logic [PCS_DW-1:0] host_wdata_out
);
   // Idle bus at time zero
   initial begin
      host_wr_out = 1'b0;
      host_rd_out = 1'b0;
      host_sel_out = 2'h0;
      host_wdata_out = 16'h0000;
   end
   // One word write; ones clear flags, bit 5 restarts the adapter
   task automatic write_word(input logic [1:0] sel, input logic [PCS_DW-1:0] data);
      @(posedge core_clk_in);
      host_sel_out <= sel;
      host_wdata_out <= data;
      host_wr_out <= 1'b1;
      @(posedge core_clk_in);
      host_wr_out <= 1'b0;
      host_wdata_out <= ~data; // Released data no longer valid
   endtask
   // One word read; result lands in the next cycle
   task automatic read_word(input logic [1:0] sel);
      @(posedge core_clk_in);
      host_sel_out <= sel;
      host_rd_out <= 1'b1;
      @(posedge core_clk_in);
      host_rd_out <= 1'b0;
   endtask
endmodule

// File: test/pcs_regs_tb.sv
`timescale 1ns/100ps
module pcs_regs_tb;
   import pcs_pkg::*;
   localparam int RC = 2;
   logic clk, resetn, clk_en, host_wr, host_rd, host_irq, fw_state_wr, fw_fatal, fw_timeout;
   logic fw_test_wr, xcvr_pin, cable_pin, cmd_valid, adapter_reset, rq, rq2;
   logic [1:0] host_sel;
   logic [15:0] host_wdata, host_rdata;
   logic [7:0] fw_flag_set, f, c;
   logic [3:0] fw_state, cmd_code;
   logic [5:0] fw_test_code, t;
   logic [15:0] eq[$], mq[$];
   int num_errors = 0;
   int checks_done = 0;
   pcs_host_model i_pcs_host_model (.core_clk_in(clk), .host_wr_out(host_wr),
      .host_rd_out(host_rd), .host_sel_out(host_sel), .host_wdata_out(host_wdata));
   pcs_regs #(.RESET_CYCLES(RC)) i_pcs_regs (.core_clk_in(clk), .resetn_in(resetn),
      .clk_en_in(clk_en), .host_wr_in(host_wr), .host_rd_in(host_rd), .host_sel_in(host_sel),
      .host_wdata_in(host_wdata), .host_rdata_out(host_rdata), .host_irq_out(host_irq),
      .fw_flag_set_in(fw_flag_set), .fw_state_wr_in(fw_state_wr), .fw_state_in(fw_state),
      .fw_fatal_in(fw_fatal), .fw_timeout_in(fw_timeout), .fw_test_wr_in(fw_test_wr),
      .fw_test_code_in(fw_test_code), .xcvr_fault_pin_in(xcvr_pin),
      .cable_fault_pin_in(cable_pin), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
      .adapter_reset_out(adapter_reset));
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [1:0] s, input logic [15:0] d);
      i_pcs_host_model.write_word(s, d);
   endtask
   // Note the expected read word, then read
   task automatic rd_chk(input logic [1:0] s, input logic [15:0] e, input logic [15:0] m);
      eq.push_back(e & m);
      mq.push_back(m);
      i_pcs_host_model.read_word(s);
   endtask
   // End firmware pulses
   task automatic clr();
      fw_flag_set <= 8'h00;
      fw_state_wr <= 1'b0;
      fw_fatal <= 1'b0;
      fw_timeout <= 1'b0;
      fw_test_wr <= 1'b0;
   endtask
   task automatic wait_rst();
      int n;
      n = 0;
      tick(2);
      while (adapter_reset !== 1'b0 && n < 50) begin
         tick(1);
         n++;
      end
      cmp("reset_done", 16'h0000, {15'h0, adapter_reset});
      tick(2);
   endtask
   // Read monitor: compares the oldest note on the falling edge after the read strobe has passed rq and rq2
   always @(posedge clk) begin
      rq <= host_rd;
      rq2 <= rq;
   end
   always @(negedge clk) begin
      if (rq2 === 1'b1) cmp("rdata", eq.pop_front(), host_rdata & mq.pop_front());
   end
   // Watchdog
   initial begin
      #80000;
      num_errors++;
      conclude();
   end
   initial begin
      {resetn, fw_flag_set, fw_state_wr, fw_state, fw_fatal, fw_timeout} = '0;
      {fw_test_wr, fw_test_code, xcvr_pin, cable_pin, rq, rq2} = '0;
      clk_en = 1'b1;
      void'($urandom(32'h1fb1));
      tick(12);
      resetn <= 1'b1;
      wait_rst();
      rd_chk(PCS_REG_CTRL, 16'h0880, 16'hfff0);
      rd_chk(PCS_REG_STAT, 16'h0002, 16'hffff);
      $display("power-up test done");
      for (int i = 0; i < 4; i++) begin
         f = 8'($urandom);
         c = 8'($urandom);
         wr(PCS_REG_CTRL, 16'hffc0);
         tick(1);
         fw_flag_set <= f;
         tick(1);
         clr();
         rd_chk(PCS_REG_CTRL, {f & FLAG_MASK, |(f & FLAG_MASK), 7'h40}, 16'hffff);
         cmp("irq", {15'h0, |(f & FLAG_MASK)}, {15'h0, host_irq});
         wr(PCS_REG_CTRL, {c, 8'h40});
         rd_chk(PCS_REG_CTRL, {f & FLAG_MASK & ~c, |(f & FLAG_MASK & ~c), 7'h40}, 16'hffff);
      end
      $display("flag test done");
      for (int k = 9; k < 15; k++) begin
         wr(PCS_REG_CTRL, 16'hff00);
         wr(PCS_REG_CTRL, 16'(k));
         rd_chk(PCS_REG_CTRL, 16'h0880 | 16'(k), 16'hffff);
         rd_chk(PCS_REG_STAT, 16'h0002, 16'h000f);
         cmp("irq", 16'h0000, {15'h0, host_irq});
      end
      $display("reserved code test done");
      wr(PCS_REG_CTRL, 16'h000f);
      rd_chk(PCS_REG_STAT, 16'h0002, 16'h000f);
      tick(1);
      fw_state_wr <= 1'b1;
      fw_state <= ST_RUNNING;
      tick(1);
      clr();
      rd_chk(PCS_REG_STAT, 16'h0003, 16'h000f);
      wr(PCS_REG_CTRL, 16'h000f);
      rd_chk(PCS_REG_STAT, 16'h0002, 16'h000f);
      $display("stop test done");
      t = 6'($urandom);
      tick(1);
      {xcvr_pin, cable_pin, fw_test_wr, fw_timeout} <= 4'hf;
      fw_test_code <= t;
      tick(1);
      clr();
      tick(4);
      rd_chk(PCS_REG_STAT, {2'b11, t, 8'h82}, 16'hffff);
      // Firmware pulse while the clock enable is low must be lost
      tick(1);
      clk_en <= 1'b0;
      fw_flag_set <= 8'h04;
      tick(1);
      clr();
      tick(1);
      clk_en <= 1'b1;
      rd_chk(PCS_REG_CTRL, 16'h0000, 16'h0400);
      $display("status test done");
      tick(1);
      fw_fatal <= 1'b1;
      tick(1);
      clr();
      rd_chk(PCS_REG_STAT, 16'h0007, 16'h000f);
      rd_chk(PCS_REG_CTRL, 16'h0180, 16'h0180);
      tick(1);
      fw_state_wr <= 1'b1;
      fw_state <= ST_READY;
      tick(1);
      clr();
      wr(PCS_REG_CTRL, 16'h000f);
      rd_chk(PCS_REG_STAT, 16'h0007, 16'h000f);
      wr(PCS_REG_CTRL, 16'h0020);
      wait_rst();
      rd_chk(PCS_REG_CTRL, 16'h0880, 16'hfff0);
      rd_chk(PCS_REG_STAT, 16'hc002, 16'hc0ff);
      tick(4);
      $display("fatal and reset test done");
      conclude();
   end
endmodule
